// File: rtl/pqs_pkg.sv
package pqs_pkg;

  // Register offsets on the management register port
  localparam logic [4:0] PQS_ANEXP_OFS   = 5'h06;
  localparam logic [4:0] PQS_STATUS_OFS  = 5'h10;
  localparam logic [4:0] PQS_FCCNT_OFS   = 5'h14;
  localparam logic [4:0] PQS_RXECNT_OFS  = 5'h15;
  localparam logic [4:0] PQS_TENBT_OFS   = 5'h1a;

  // Field positions within the status word
  localparam int PQS_RSVD_BIT     = 15;
  localparam int PQS_XOVER_BIT    = 14;
  localparam int PQS_RXERR_BIT    = 13;
  localparam int PQS_POL_BIT      = 12;
  localparam int PQS_FCAR_BIT     = 11;
  localparam int PQS_SIGDET_BIT   = 10;
  localparam int PQS_DSLOCK_BIT   = 9;
  localparam int PQS_PAGE_BIT     = 8;
  localparam int PQS_TENBT_POL_BIT = 4;
  localparam int PQS_ANEXP_PAGE_BIT = 1;

  // Reset value of the upper byte
  localparam logic [7:0] PQS_UPPER_RST = 8'h00;

  // Live indications from the PHY core
  typedef struct packed {
    logic auto_crossover_enable;
    logic force_crossover;
    logic force_crossover_swap;
    logic algo_crossed;
    logic rx_error_evt;
    logic false_carrier_evt;
    logic pol_inverted;
    logic sig_detect;
    logic dscr_lock;
    logic page_rx_evt;
  } pqs_phy_t;

  // Register read strobe
  typedef struct packed {
    logic       rd_stb;
    logic [4:0] rd_addr;
  } pqs_rd_t;

endpackage

// File: rtl/pqs_status_upper.sv
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Bit 15 reserved, reads zero, writes ignored
// - Bit 14 shows crossover state from negotiation
// - Crossover follows enable/force, dynamic when automatic
// - Bit 13 latches rx error, cleared reading 0x15
// - Bit 12 latches inverted polarity bit
// - Polarity cleared by 10M status read only
// - Bit 11 latches false carrier, cleared reading 0x14
// - Bit 10 signal detect, latch low
// - Bit 9 descrambler lock, latch low
// - Bit 8 page received, cleared reading 0x06
module pqs_status_upper
  import pqs_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        clk_en_in,
  // PHY indications (same clock domain)
  input  wire pqs_phy_t    phy_in,
  // Register read port
  input  wire pqs_rd_t     rd_in,
  // Upper status byte
  output logic      [15:8] status_upper_out
);

  // Status byte and next value
  logic [7:0] stat_q;
  logic [7:0] stat_d;

  // Latch-low holders
  logic       sd_ll_q;
  logic       sd_ll_d;
  logic       dl_ll_q;
  logic       dl_ll_d;

  // Polarity holder
  logic       pol_q;
  logic       pol_d;

  // Address match of a read strobe
  function automatic logic rd_hit(input pqs_rd_t r, input logic [4:0] ofs);
    rd_hit = r.rd_stb && (r.rd_addr == ofs);
  endfunction

  // Sticky flag, set wins over clear
  function automatic logic sticky_next(input logic set, input logic held, input logic clr);
    sticky_next = set | (held & ~clr);
  endfunction

  // Latch-low flag, rearmed by a read
  function automatic logic low_next(input logic live, input logic held, input logic rearm);
    low_next = rearm ? live : (held & live);
  endfunction

  // Read decodes
  wire logic rd_status = rd_hit(rd_in, PQS_STATUS_OFS);
  wire logic rd_rxecnt = rd_hit(rd_in, PQS_RXECNT_OFS);
  wire logic rd_fccnt  = rd_hit(rd_in, PQS_FCCNT_OFS);
  wire logic rd_tenbt  = rd_hit(rd_in, PQS_TENBT_OFS);
  wire logic rd_anexp  = rd_hit(rd_in, PQS_ANEXP_OFS);

  // Held flags
  wire logic rxerr_held = stat_q[PQS_RXERR_BIT-8];
  wire logic fcar_held  = stat_q[PQS_FCAR_BIT-8];
  wire logic page_held  = stat_q[PQS_PAGE_BIT-8];

  wire logic auto_xover = phy_in.auto_crossover_enable & phy_in.algo_crossed;
  wire logic xover      = phy_in.force_crossover ? phy_in.force_crossover_swap : auto_xover;

  wire logic rxerr_d = sticky_next(phy_in.rx_error_evt, rxerr_held, rd_rxecnt);
  wire logic fcar_d  = sticky_next(phy_in.false_carrier_evt, fcar_held, rd_fccnt);
  wire logic page_d  = sticky_next(phy_in.page_rx_evt, page_held, rd_anexp);

  // polarity cleared by 10M status read
  assign pol_d = sticky_next(phy_in.pol_inverted, pol_q, rd_tenbt);

  // latch low, rearmed on status read
  assign sd_ll_d = low_next(phy_in.sig_detect, sd_ll_q, rd_status);
  // latch low, rearmed on status read
  assign dl_ll_d = low_next(phy_in.dscr_lock, dl_ll_q, rd_status);

  assign stat_d = {1'b0, xover, rxerr_d, pol_d, fcar_d, sd_ll_d, dl_ll_d, page_d};

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      stat_q  <= PQS_UPPER_RST;
      sd_ll_q <= 1'b0;
      dl_ll_q <= 1'b0;
      pol_q   <= 1'b0;
    end else if (clk_en_in) begin
      stat_q  <= stat_d;
      sd_ll_q <= sd_ll_d;
      dl_ll_q <= dl_ll_d;
      pol_q   <= pol_d;
    end
  end

  // Registered status byte
  assign status_upper_out = stat_q;

  // Assertions
  reserved_zero_a: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in)
    status_upper_out[PQS_RSVD_BIT]
    == 1'b0)
    else $error("reserved bit set");

  xover_track_a: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in)
    clk_en_in && !phy_in.force_crossover && phy_in.auto_crossover_enable
    |=> status_upper_out[PQS_XOVER_BIT] == $past(phy_in.algo_crossed))
    else $error("crossover not tracking");

  xover_force_a: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in)
    clk_en_in && phy_in.force_crossover
    |=> status_upper_out[PQS_XOVER_BIT] == $past(phy_in.force_crossover_swap))
    else $error("forced crossover not shown");

  xover_off_a: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in)
    clk_en_in && !phy_in.force_crossover && !phy_in.auto_crossover_enable
    |=> !status_upper_out[PQS_XOVER_BIT])
    else $error("crossover set while off");

  rxerr_latch_a: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in)
    clk_en_in && phy_in.rx_error_evt
    |=> status_upper_out[PQS_RXERR_BIT])
    else $error("rx error not latched");

  rxerr_hold_a: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in)
    status_upper_out[PQS_RXERR_BIT] && !rd_rxecnt
    |=> status_upper_out[PQS_RXERR_BIT])
    else $error("rx error dropped early");

  rxerr_clear_a: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in)
    clk_en_in && rd_rxecnt && !phy_in.rx_error_evt
    |=> !status_upper_out[PQS_RXERR_BIT])
    else $error("rx error not cleared");

  rxerr_noset_a: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in)
    !status_upper_out[PQS_RXERR_BIT] && !phy_in.rx_error_evt
    |=> !status_upper_out[PQS_RXERR_BIT])
    else $error("rx error set without event");

  pol_set_a: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in)
    clk_en_in && phy_in.pol_inverted
    |=> status_upper_out[PQS_POL_BIT])
    else $error("polarity not shown");

  pol_noset_a: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in)
    !status_upper_out[PQS_POL_BIT] && !phy_in.pol_inverted
    |=> !status_upper_out[PQS_POL_BIT])
    else $error("polarity set while correct");

  pol_keep_a: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in)
    status_upper_out[PQS_POL_BIT] && !rd_tenbt
    |=> status_upper_out[PQS_POL_BIT])
    else $error("polarity cleared wrongly");

  pol_clear_a: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in)
    clk_en_in && rd_tenbt && !phy_in.pol_inverted
    |=> !status_upper_out[PQS_POL_BIT])
    else $error("polarity not cleared");

  fcar_latch_a: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in)
    clk_en_in && phy_in.false_carrier_evt
    |=> status_upper_out[PQS_FCAR_BIT])
    else $error("false carrier not latched");

  fcar_hold_a: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in)
    status_upper_out[PQS_FCAR_BIT] && !rd_fccnt
    |=> status_upper_out[PQS_FCAR_BIT])
    else $error("false carrier dropped early");

  fcar_clear_a: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in)
    clk_en_in && rd_fccnt && !phy_in.false_carrier_evt
    |=> !status_upper_out[PQS_FCAR_BIT])
    else $error("false carrier not cleared");

  fcar_noset_a: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in)
    !status_upper_out[PQS_FCAR_BIT] && !phy_in.false_carrier_evt
    |=> !status_upper_out[PQS_FCAR_BIT])
    else $error("false carrier set without event");

  sd_lowhold_a: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in)
    !status_upper_out[PQS_SIGDET_BIT] && !rd_status
    |=> !status_upper_out[PQS_SIGDET_BIT])
    else $error("signal detect left latch");

  sd_drop_a: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in)
    clk_en_in && !phy_in.sig_detect
    |=> !status_upper_out[PQS_SIGDET_BIT])
    else $error("signal detect loss missed");

  dl_lowhold_a: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in)
    !status_upper_out[PQS_DSLOCK_BIT] && !rd_status
    |=> !status_upper_out[PQS_DSLOCK_BIT])
    else $error("lock left latch");

  dl_drop_a: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in)
    clk_en_in && !phy_in.dscr_lock
    |=> !status_upper_out[PQS_DSLOCK_BIT])
    else $error("lock loss missed");

  page_set_a: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in)
    clk_en_in && phy_in.page_rx_evt
    |=> status_upper_out[PQS_PAGE_BIT])
    else $error("page not latched");

  page_keep_a: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in)
    status_upper_out[PQS_PAGE_BIT] && !rd_anexp
    |=> status_upper_out[PQS_PAGE_BIT])
    else $error("page bit cleared wrongly");

  page_clear_a: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in)
    clk_en_in && rd_anexp && !phy_in.page_rx_evt
    |=> !status_upper_out[PQS_PAGE_BIT])
    else $error("page bit not cleared");

  page_noset_a: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in)
    !status_upper_out[PQS_PAGE_BIT] && !phy_in.page_rx_evt
    |=> !status_upper_out[PQS_PAGE_BIT])
    else $error("page set without event");

  rearm_follow_a: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in)
    clk_en_in && rd_status
    |=> status_upper_out[PQS_SIGDET_BIT] == $past(phy_in.sig_detect))
    else $error("latch low not rearmed");

  dl_rearm_a: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in)
    clk_en_in && rd_status
    |=> status_upper_out[PQS_DSLOCK_BIT] == $past(phy_in.dscr_lock))
    else $error("lock latch not rearmed");

  sd_high_a: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in)
    status_upper_out[PQS_SIGDET_BIT] && phy_in.sig_detect
    |=> status_upper_out[PQS_SIGDET_BIT])
    else $error("signal detect dropped while live");

  dl_high_a: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in)
    status_upper_out[PQS_DSLOCK_BIT] && phy_in.dscr_lock
    |=> status_upper_out[PQS_DSLOCK_BIT])
    else $error("lock dropped while live");

  hold_freeze_a: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in)
    !clk_en_in
    |=> $stable(status_upper_out))
    else $error("state moved while frozen");

  reset_clear_a: assert property (@(posedge core_clk_in)
    sys_rst_in
    |=> status_upper_out == 8'h00)
    else $error("reset did not clear");

  // Main scenarios
  rxerr_seen_c: cover property (@(posedge core_clk_in) phy_in.rx_error_evt ##1 rd_rxecnt);
  sd_drop_c: cover property (@(posedge core_clk_in)
    !status_upper_out[PQS_SIGDET_BIT] ##1 rd_status ##1 status_upper_out[PQS_SIGDET_BIT]);
  xover_c: cover property (@(posedge core_clk_in) $rose(status_upper_out[PQS_XOVER_BIT]));
  pol_clear_c: cover property (@(posedge core_clk_in)
    status_upper_out[PQS_POL_BIT] ##1 rd_tenbt ##1 !status_upper_out[PQS_POL_BIT]);
  page_clear_c: cover property (@(posedge core_clk_in)
    status_upper_out[PQS_PAGE_BIT] ##1 rd_anexp ##1 !status_upper_out[PQS_PAGE_BIT]);

endmodule

`default_nettype wire

// File: verification/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import pqs_pkg::*;
  logic        core_clk_in;
  logic        sys_rst_in;
  logic        clk_en_in;
  pqs_phy_t    phy;
  pqs_rd_t     rd;
  logic [15:8] st;
  int          fails;
  int          n_compared;
  pqs_status_upper i_pqs_status_upper (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in), .phy_in(phy), .rd_in(rd), .status_upper_out(st));
  initial begin
    core_clk_in = 1'b0;
    forever #25 core_clk_in = ~core_clk_in;
  end
  task automatic tick;
    @(negedge core_clk_in);
  endtask
  task automatic chk(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd_reg(input logic [4:0] a);
    rd = '{rd_stb: 1'b1, rd_addr: a};
    tick();
    rd.rd_stb = 1'b0;
    tick();
  endtask
  task automatic do_reset;
    sys_rst_in = 1'b1;
    repeat (10) tick();
    for (int b = 8; b < 16; b++) chk(st[b], 1'b0);
    sys_rst_in = 1'b0;
    tick();
    chk(st[10], 1'b0);
  endtask
  task automatic t_freeze;
    clk_en_in = 1'b0;
    phy.rx_error_evt = 1'b1;
    tick();
    phy.rx_error_evt = 1'b0;
    clk_en_in = 1'b1;
    tick();
    chk(st[13], 1'b0);
  endtask
  task automatic t_xover;
    logic e;
    for (int i = 0; i < 16; i++) begin
      {phy.auto_crossover_enable, phy.force_crossover, phy.force_crossover_swap,
        phy.algo_crossed} = 4'(i);
      tick();
      e = i[2] ? i[1] : (i[3] & i[0]);
      chk(st[14], e);
      chk(st[15], 1'b0);
    end
  endtask
  // Event latch held across status reads, cleared only by its own read
  task automatic t_latch(input int pb, input int sb, input logic [4:0] a);
    phy[pb] = 1'b1;
    tick();
    phy[pb] = 1'b0;
    tick();
    chk(st[sb], 1'b1);
    rd_reg(PQS_STATUS_OFS);
    chk(st[sb], 1'b1);
    phy[pb] = 1'b1;
    rd = '{rd_stb: 1'b1, rd_addr: a};
    tick();
    phy[pb] = 1'b0;
    rd.rd_stb = 1'b0;
    tick();
    chk(st[sb], 1'b1);
    rd_reg(a);
    chk(st[sb], 1'b0);
  endtask
  task automatic t_pol;
    phy.pol_inverted = 1'b1;
    tick();
    phy.pol_inverted = 1'b0;
    chk(st[12], 1'b1);
    rd_reg(PQS_STATUS_OFS);
    chk(st[12], 1'b1);
    rd_reg(PQS_TENBT_OFS);
    chk(st[12], 1'b0);
  endtask
  task automatic t_low(input int pb, input int sb);
    rd_reg(PQS_STATUS_OFS);
    chk(st[sb], 1'b1);
    phy[pb] = 1'b0;
    tick();
    phy[pb] = 1'b1;
    repeat (2) tick();
    chk(st[sb], 1'b0);
    rd_reg(PQS_STATUS_OFS);
    chk(st[sb], 1'b1);
  endtask
  task automatic results;
    $display("Counts: compared=%0d fails=%0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    fails = 0;
    n_compared = 0;
    clk_en_in = 1'b1;
    phy = '0;
    phy.sig_detect = 1'b1;
    phy.dscr_lock = 1'b1;
    rd = '0;
    do_reset();
    t_freeze();
    t_xover();
    t_latch(5, 13, PQS_RXECNT_OFS);
    t_latch(4, 11, PQS_FCCNT_OFS);
    t_latch(0, 8, PQS_ANEXP_OFS);
    t_pol();
    t_low(2, 10);
    t_low(1, 9);
    phy.rx_error_evt = 1'b1;
    tick();
    phy.rx_error_evt = 1'b0;
    do_reset();
    results();
  end
endmodule
`default_nettype wire
